//--- hw/vector_fetch.sv
// vector fetch unit: reads one 24-bit handler address from program memory
// assumes program memory answers a read with data in the same cycle as the read strobe
module vector_fetch (
   input  wire logic                       mclk_in,
   input  wire logic                       rst_in,
   input  wire logic                       start_in,
   input  wire logic [vic_pkg::VEC_W-1:0]  vector_in,
   input  wire logic                       use_alt_in,
   input  wire logic [vic_pkg::PM_W-1:0]   alt_base_in,
   input  wire logic [vic_pkg::PM_W-1:0]   pm_data_in,
   output logic [vic_pkg::PM_W-1:0]        pm_addr_out,
   output logic                            pm_rd_out,
   output vic_pkg::handler_t               handler_out
);
   import vic_pkg::*;

   logic [PM_W-1:0] base;
   logic [PM_W-1:0] next_addr;

   assign base = use_alt_in ? alt_base_in : PRIMARY_BASE;
   // two words per vector entry
   assign next_addr = base + PM_W'({vector_in, 1'b0});

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pm_addr_out <= '0;
         pm_rd_out   <= 1'b0;
      end else begin
         pm_rd_out <= start_in;
         if (start_in) begin
            pm_addr_out <= next_addr;
         end
      end
   end

   // always one read cycle, so entry latency never varies
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         handler_out <= '0;
      end else begin
         handler_out.valid <= pm_rd_out;
         if (pm_rd_out) begin
            handler_out.addr <= pm_data_in;
         end
      end
   end

endmodule

//--- hw/vectored_interrupt_controller.sv
// vectored interrupt controller: flags, enables, priorities, arbitration,
// grant handshake to the core and vector fetch
// assumes a core that acknowledges a grant and raises its own level
//
// The register addresses and strobed register access are this design's own decisions.
import vic_pkg::*;
module vectored_interrupt_controller (
   input  wire logic                          mclk_in,
   input  wire logic                          rst_in,
   input  wire logic [vic_pkg::NUM_REQ-1:0]   src_req_in,
   input  wire logic [vic_pkg::NUM_TRAPS-1:0] trap_in,
   input  wire vic_pkg::reg_req_t             reg_in,
   output logic [vic_pkg::DATA_W-1:0]         rdata_out,
   input  wire logic [vic_pkg::LEVEL_W-1:0]   core_level_in,
   input  wire logic                          core_ack_in,
   input  wire logic                          core_ret_in,
   output vic_pkg::grant_t                    grant_out,
   output vic_pkg::handler_t                  handler_out,
   output logic                               ret_done_out,
   input  wire logic                          boot_segment_in,
   input  wire logic                          alt_table_fuse_in,
   input  wire logic [vic_pkg::PM_W-1:0]      boot_end_in,
   output logic [vic_pkg::PM_W-1:0]           pm_addr_out,
   output logic                               pm_rd_out,
   input  wire logic [vic_pkg::PM_W-1:0]      pm_data_in
);
   import vic_pkg::*;

   logic [NUM_REQ-1:0]  request_flag;
   logic [NUM_REQ-1:0]  source_enable;
   logic [PRIO_W-1:0]   source_priority [NUM_REQ];
   logic [DATA_W-1:0]   global_control_two;
   logic [VEC_W-1:0]    granted_vector_number;
   logic [LEVEL_W-1:0]  granted_level;
   grant_state_t        state;

   logic                global_irq_enable;
   logic                alt_table_enable;
   logic                use_alt;
   logic [PM_W-1:0]     alt_base;

   logic                best_ok;
   logic [LEVEL_W-1:0]  best_lvl;
   logic [VEC_W-1:0]    best_vec;
   logic                pend_valid;
   logic [LEVEL_W-1:0]  pend_lvl;
   logic [VEC_W-1:0]    pend_vec;
   logic                fetch_start;
   logic [RET_CYCLES-1:0] ret_pipe;

   assign global_irq_enable = global_control_two[GIE_BIT];
   assign alt_table_enable  = global_control_two[ALT_EN_BIT];
   assign use_alt  = boot_segment_in & alt_table_enable & alt_table_fuse_in;
   assign alt_base = last_page_base(boot_end_in);

   function automatic logic [ADDR_W-1:0] flag_addr(input int r);
      return FLAG_BASE + ADDR_W'(r / REQ_PER_WORD);
   endfunction

   function automatic logic [ADDR_W-1:0] en_addr(input int r);
      return EN_BASE + ADDR_W'(r / REQ_PER_WORD);
   endfunction

   function automatic logic [ADDR_W-1:0] prio_addr(input int r);
      return PRIO_BASE + ADDR_W'(r / PRIO_PER_WORD);
   endfunction

   function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
      return reg_in.wr && (reg_in.addr == a);
   endfunction

   // request flags: source or software sets, software clears, set wins
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         request_flag <= '0;
      end else begin
         for (int r = 0; r < NUM_REQ; r++) begin
            if (is_reserved(r)) begin
               request_flag[r] <= 1'b0;
            end else if (wr_hit(flag_addr(r))) begin
               request_flag[r] <= reg_in.wdata[r % REQ_PER_WORD] |
                                  src_req_in[r];
            end else begin
               request_flag[r] <= request_flag[r] | src_req_in[r];
            end
         end
      end
   end

   // individual enables
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         source_enable <= '0;
      end else begin
         for (int r = 0; r < NUM_REQ; r++) begin
            if (is_reserved(r)) begin
               source_enable[r] <= 1'b0;
            end else if (wr_hit(en_addr(r))) begin
               source_enable[r] <= reg_in.wdata[r % REQ_PER_WORD];
            end
         end
      end
   end

   // priorities, three bits per source, four sources per word
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         for (int r = 0; r < NUM_REQ; r++) begin
            source_priority[r] <= PRIO_OFF;
         end
      end else begin
         for (int r = 0; r < NUM_REQ; r++) begin
            if (is_reserved(r)) begin
               source_priority[r] <= PRIO_OFF;
            end else if (wr_hit(prio_addr(r))) begin
               source_priority[r] <=
                  reg_in.wdata[PRIO_STRIDE*(r % PRIO_PER_WORD) +: PRIO_W];
            end
         end
      end
   end

   // global control
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         global_control_two <= CTRL_RESET;
      end else if (wr_hit(CTRL_ADDR)) begin
         global_control_two <= '0;
         global_control_two[GIE_BIT]    <= reg_in.wdata[GIE_BIT];
         global_control_two[ALT_EN_BIT] <= reg_in.wdata[ALT_EN_BIT];
      end
   end

   // read port, data in the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= '0;
      end else if (reg_in.rd) begin
         rdata_out <= '0;
         for (int r = 0; r < NUM_REQ; r++) begin
            if (reg_in.addr == flag_addr(r)) begin
               rdata_out[r % REQ_PER_WORD] <= request_flag[r];
            end
            if (reg_in.addr == en_addr(r)) begin
               rdata_out[r % REQ_PER_WORD] <= source_enable[r];
            end
            if (reg_in.addr == prio_addr(r)) begin
               rdata_out[PRIO_STRIDE*(r % PRIO_PER_WORD) +: PRIO_W] <=
                  source_priority[r];
            end
         end
         if (reg_in.addr == CTRL_ADDR) begin
            rdata_out <= global_control_two;
         end
         if (reg_in.addr == GRANT_ADDR) begin
            rdata_out <= '0;
            rdata_out[VEC_W-1:0] <= granted_vector_number;
            rdata_out[GRANT_LVL_LSB +: LEVEL_W] <= granted_level;
         end
      end
   end

   // arbitration: highest level, then lowest vector
   always_comb begin
      best_ok  = 1'b0;
      best_lvl = LEVEL_NONE;
      best_vec = '0;
      // descending scan with >= leaves the lowest number on a tie
      for (int r = NUM_REQ - 1; r >= 0; r--) begin
         if (!is_reserved(r) && request_flag[r] && source_enable[r] &&
             global_irq_enable && (source_priority[r] != PRIO_OFF) &&
             ({1'b0, source_priority[r]} >= best_lvl)) begin
            best_ok  = 1'b1;
            best_lvl = {1'b0, source_priority[r]};
            best_vec = VEC_W'(r + VEC_OFFSET);
         end
      end
      // traps sit above every user level and ignore the global enable
      for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
         if (trap_in[t]) begin
            best_ok  = 1'b1;
            best_lvl = TRAP_TOP_LEVEL - LEVEL_W'(t);
            best_vec = VEC_W'(t);
         end
      end
   end

   // pending winner registered against the core level
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pend_valid <= 1'b0;
         pend_lvl   <= LEVEL_NONE;
         pend_vec   <= '0;
      end else begin
         pend_valid <= best_ok &&
                       (best_lvl > core_level_in);
         pend_lvl   <= best_lvl;
         pend_vec   <= best_vec;
      end
   end

   // grant handshake with the core
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state       <= ST_IDLE;
         grant_out   <= '0;
         fetch_start <= 1'b0;
      end else begin
         fetch_start <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (pend_valid && (pend_lvl > core_level_in)) begin
                  grant_out.req    <= 1'b1;
                  grant_out.level  <= pend_lvl;
                  grant_out.vector <= pend_vec;
                  state            <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (core_ack_in) begin
                  grant_out.req <= 1'b0;
                  fetch_start   <= 1'b1;
                  state         <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (handler_out.valid) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // granted vector and level, latched on acknowledge
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         granted_vector_number <= '0;
         granted_level         <= LEVEL_NONE;
      end else if ((state == ST_REQ) && core_ack_in) begin
         granted_vector_number <= grant_out.vector;
         granted_level         <= grant_out.level;
      end
   end

   // return latency is a fixed pipe
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ret_pipe     <= '0;
         ret_done_out <= 1'b0;
      end else begin
         ret_pipe     <= {ret_pipe[RET_CYCLES-2:0], core_ret_in};
         ret_done_out <= ret_pipe[RET_CYCLES-1];
      end
   end

   vector_fetch u_fetch (
      .mclk_in     (mclk_in),
      .rst_in      (rst_in),
      .start_in    (fetch_start),
      .vector_in   (granted_vector_number),
      .use_alt_in  (use_alt),
      .alt_base_in (alt_base),
      .pm_data_in  (pm_data_in),
      .pm_addr_out (pm_addr_out),
      .pm_rd_out   (pm_rd_out),
      .handler_out (handler_out)
   );

   // vector space check: traps plus requests fit the slot count
   localparam int SLOT_CHECK = NUM_VECTORS - VEC_OFFSET - NUM_REQ;

endmodule

//--- hw/vic_pkg.sv
// constants, register map and carrier types of the vectored interrupt
// controller; shared by the controller top and its vector fetch unit
package vic_pkg;

   localparam int NUM_VECTORS = 246;
   localparam int NUM_TRAPS   = 7;
   localparam int NUM_REQ     = 187;
   localparam int VEC_OFFSET  = 8;
   localparam int FLAG_WORDS  = 12;
   localparam int PRIO_WORDS  = 47;
   localparam int REQ_PER_WORD  = 16;
   localparam int PRIO_PER_WORD = 4;
   localparam int PRIO_STRIDE   = 4;

   localparam int DATA_W  = 16;
   localparam int ADDR_W  = 8;
   localparam int PRIO_W  = 3;
   localparam int LEVEL_W = 4;
   localparam int VEC_W   = 8;
   localparam int PM_W    = 24;

   // register map, word addresses on the register port
   localparam logic [ADDR_W-1:0] FLAG_BASE  = 8'h00;
   localparam logic [ADDR_W-1:0] EN_BASE    = 8'h10;
   localparam logic [ADDR_W-1:0] PRIO_BASE  = 8'h20;
   localparam logic [ADDR_W-1:0] CTRL_ADDR  = 8'h50;
   localparam logic [ADDR_W-1:0] GRANT_ADDR = 8'h51;

   // global_control_two fields
   localparam int GIE_BIT    = 15;
   localparam int ALT_EN_BIT = 8;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

   // granted_vector_reg fields
   localparam int GRANT_LVL_LSB = 8;

   localparam logic [PM_W-1:0] PRIMARY_BASE = 24'h00_0004;
   localparam logic [PM_W-1:0] PAGE_MASK    = 24'h00_07ff;
   localparam logic [LEVEL_W-1:0] TRAP_TOP_LEVEL = 4'hf;
   localparam logic [LEVEL_W-1:0] LEVEL_NONE     = 4'h0;
   localparam logic [PRIO_W-1:0]  PRIO_OFF       = 3'h0;

   localparam int RET_CYCLES = 2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_REQ   = 2'b01,
      ST_FETCH = 2'b11
   } grant_state_t;

   typedef struct packed {
      logic               req;
      logic [LEVEL_W-1:0] level;
      logic [VEC_W-1:0]   vector;
   } grant_t;

   typedef struct packed {
      logic            valid;
      logic [PM_W-1:0] addr;
   } handler_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   // request numbers with no flag, enable or priority bits
   function automatic logic is_reserved(input int r);
      return (r == 46) || (r == 61) || (r == 63) || (r == 64) ||
             (r == 68) || (r == 69) || (r == 72) || (r == 74) ||
             (r == 76) || (r >= 78 && r <= 80) ||
             (r >= 84 && r <= 86) || (r == 92) || (r == 93) ||
             (r >= 100 && r <= 141) || (r == 144);
   endfunction

   // first word of the final page of the boot segment
   function automatic logic [PM_W-1:0] last_page_base(
      input logic [PM_W-1:0] boot_end);
      return boot_end & ~PAGE_MASK;
   endfunction

endpackage

//--- tb/core_model.sv
// core and program memory stand-in on the controller's grant side
// assumes one grant at a time; memory answers in the read cycle
module core_model (
   input  wire logic                        mclk_in,
   input  wire logic                        rst_in,
   input  wire logic                        slow_in,
   input  wire logic [vic_pkg::LEVEL_W-1:0] base_level_in,
   input  wire vic_pkg::grant_t             grant_in,
   input  wire vic_pkg::handler_t           handler_in,
   input  wire logic                        ret_done_in,
   input  wire logic [vic_pkg::PM_W-1:0]    pm_addr_in,
   input  wire logic                        pm_rd_in,
   output logic [vic_pkg::LEVEL_W-1:0]      core_level_out,
   output logic                             core_ack_out,
   output logic                             core_ret_out,
   output logic [vic_pkg::PM_W-1:0]         pm_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import vic_pkg::*;
   logic [2:0]      dly;
   logic [2:0]      isr;
   logic            in_isr;
   logic            rd_d;
   logic [PM_W-1:0] last;
   logic [PM_W-1:0] junk;

   // grant acceptance, prompt or after a stall
   always_ff @(posedge mclk_in) begin
      core_ack_out <= 1'b0;
      if (rst_in || !grant_in.req || core_ack_out) begin
         dly <= slow_in ? 3'h3 : 3'h0;
      end else if (dly != 3'h0) begin
         dly <= dly - 3'h1;
      end else begin
         core_ack_out <= 1'b1;
      end
   end

   // handler run, return and current level
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         in_isr <= 1'b0;
         isr <= 3'h0;
         core_ret_out <= 1'b0;
         core_level_out <= 4'h0;
      end else begin
         core_ret_out <= (isr == 3'h1);
         if (handler_in.valid)
            isr <= 3'h6;
         else if (isr != 3'h0)
            isr <= isr - 3'h1;
         if (grant_in.req && core_ack_out) begin
            in_isr <= 1'b1;
            core_level_out <= grant_in.level;
         end else if (ret_done_in)
            in_isr <= 1'b0;
         else if (!in_isr)
            core_level_out <= base_level_in;
      end
   end

   // memory: table word is its address scrambled, held one cycle after the read; junk otherwise
   always_ff @(posedge mclk_in) begin
      rd_d <= pm_rd_in;
      junk <= rst_in ? 24'h00_0000 : ~junk;
      if (pm_rd_in)
         last <= pm_addr_in;
   end
   assign pm_data_out = pm_rd_in ? pm_addr_in ^ 24'h5a_a5c3 :
                        rd_d ? last ^ 24'h5a_a5c3 : junk;
endmodule

//--- tb/testbench.sv
// self-checking bench: controller against the core and memory model
// assumes the package constants and core_model beside the controller
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import vic_pkg::*;
   logic                 mclk_in = 1'b0;
   logic                 rst_in = 1'b1;
   logic [NUM_REQ-1:0]   src_req_in = '0;
   logic [NUM_TRAPS-1:0] trap_in = '0;
   reg_req_t             reg_in = '0;
   logic                 boot_segment_in = 1'b0;
   logic                 alt_table_fuse_in = 1'b0;
   logic [PM_W-1:0]      boot_end_in = 24'h01_23a6;
   logic                 slow = 1'b0;
   logic [LEVEL_W-1:0]   base_level = 4'h0;
   logic [LEVEL_W-1:0]   core_level_in;
   logic                 core_ack_in, core_ret_in, ret_done_out, pm_rd_out;
   logic [DATA_W-1:0]    rdata_out;
   logic [PM_W-1:0]      pm_addr_out, pm_data_in;
   grant_t               grant_out;
   handler_t             handler_out;
   int                   n_errors = 0, cmp_count = 0, seed = 32'h3b35;
   int                   x, r, p, n;

   vectored_interrupt_controller i_vectored_interrupt_controller (
      .mclk_in, .rst_in, .src_req_in, .trap_in, .reg_in, .rdata_out,
      .core_level_in, .core_ack_in, .core_ret_in, .grant_out,
      .handler_out, .ret_done_out, .boot_segment_in, .alt_table_fuse_in,
      .boot_end_in, .pm_addr_out, .pm_rd_out, .pm_data_in);
   core_model i_core_model (
      .mclk_in, .rst_in, .slow_in(slow), .base_level_in(base_level),
      .grant_in(grant_out), .handler_in(handler_out),
      .ret_done_in(ret_done_out), .pm_addr_in(pm_addr_out),
      .pm_rd_in(pm_rd_out), .core_level_out(core_level_in),
      .core_ack_out(core_ack_in), .core_ret_out(core_ret_in),
      .pm_data_out(pm_data_in));

   initial forever #12.5 mclk_in = ~mclk_in;

   task automatic final_report;
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // bounded wait: 0 grant, 1 handler, 2 return done
   task automatic wt(input int w);
      for (int k = 0; k < 60; k++) begin
         @(negedge mclk_in);
         if ((w == 0 && grant_out.req === 1'b1) ||
             (w == 1 && handler_out.valid === 1'b1) ||
             (w == 2 && ret_done_out === 1'b1))
            return;
      end
      n_errors++;
      $display("ERROR at %0t: wait ran out, got %h expected %h", $time, 0, 1);
      final_report;
   endtask

   function automatic logic [DATA_W-1:0] bit_of(input int q);
      return 16'h0001 << (q % 16);
   endfunction

   function automatic logic [PM_W-1:0] exp_h(input int v, input logic alt);
      logic [PM_W-1:0] b;
      b = alt ? (boot_end_in & 24'hff_f800) : 24'h00_0004;
      return (b + PM_W'(2 * v)) ^ 24'h5a_a5c3;
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      reg_in <= '{a, v, 1'b1, 1'b0};
      @(posedge mclk_in);
      reg_in <= '0;
      @(posedge mclk_in);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] e);
      reg_in <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge mclk_in);
      reg_in <= '0;
      #1 chk(rdata_out, e);
      @(posedge mclk_in);
   endtask

   task automatic arm(input int q, input int pr);
      wr(EN_BASE + ADDR_W'(q / 16), bit_of(q));
      wr(PRIO_BASE + ADDR_W'(q / 4), DATA_W'(pr) << (4 * (q % 4)));
   endtask

   task automatic pulse(input logic [NUM_REQ-1:0] m);
      src_req_in <= m;
      @(posedge mclk_in);
      src_req_in <= '0;
      @(posedge mclk_in);
   endtask

   task automatic idle;
      int s = 0;
      repeat (20) begin
         @(negedge mclk_in);
         if (grant_out.req !== 1'b0)
            s++;
      end
      @(posedge mclk_in);
      chk(s, 0);
   endtask

   // take one grant, check it, clear its source inside the handler
   task automatic serve(input int v, input int l, input logic alt);
      wt(0);
      chk(grant_out.vector, v);
      chk(grant_out.level, l);
      wt(1);
      chk(handler_out.addr, exp_h(v, alt));
      @(posedge mclk_in);
      trap_in <= '0;
      if (v >= 8)
         wr(FLAG_BASE + ADDR_W'((v - 8) / 16), 16'h0000);
      wt(2);
      @(posedge mclk_in);
   endtask

   initial begin
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      rd_chk(CTRL_ADDR, 16'h0000);
      rd_chk(GRANT_ADDR, 16'h0000);
      rd_chk(FLAG_BASE, 16'h0000);
      rd_chk(8'hff, 16'h0000);
      wr(CTRL_ADDR, 16'h8000);
      for (n = 0; n < 12; n++) begin
         x = $unsigned($random(seed)) % 88;
         r = x < 46 ? x : x + 99;
         p = 1 + x % 7;
         slow <= x[0];
         arm(r, p);
         if (x[1])
            wr(FLAG_BASE + ADDR_W'(r / 16), bit_of(r));
         else
            pulse(NUM_REQ'(1'b1) << r);
         serve(r + 8, p, 1'b0);
         rd_chk(GRANT_ADDR, DATA_W'(p * 256 + r + 8));
         rd_chk(FLAG_BASE + ADDR_W'(r / 16), 16'h0000);
      end
      arm(3, 4);
      arm(20, 4);
      pulse(NUM_REQ'(1'b1) << 3 | NUM_REQ'(1'b1) << 20);
      serve(11, 4, 1'b0);
      serve(28, 4, 1'b0);
      arm(3, 2);
      arm(20, 6);
      pulse(NUM_REQ'(1'b1) << 3 | NUM_REQ'(1'b1) << 20);
      serve(28, 6, 1'b0);
      serve(11, 2, 1'b0);
      arm(5, 3);
      base_level <= 4'h3;
      pulse(NUM_REQ'(1'b1) << 5);
      idle;
      base_level <= 4'h2;
      serve(13, 3, 1'b0);
      wr(CTRL_ADDR, 16'h0000);
      pulse(NUM_REQ'(1'b1) << 5);
      idle;
      wr(CTRL_ADDR, 16'h8000);
      serve(13, 3, 1'b0);
      arm(5, 0);
      pulse(NUM_REQ'(1'b1) << 5);
      idle;
      wr(FLAG_BASE, 16'h0000);
      wr(CTRL_ADDR, 16'h0000);
      base_level <= 4'h7;
      trap_in[2] <= 1'b1;
      serve(2, 13, 1'b0);
      base_level <= 4'h0;
      wr(CTRL_ADDR, 16'h8000);
      wr(EN_BASE + 8'h02, 16'h4000);
      wr(PRIO_BASE + 8'h0b, 16'hffff);
      pulse(NUM_REQ'(1'b1) << 46);
      idle;
      rd_chk(EN_BASE + 8'h02, 16'h0000);
      rd_chk(PRIO_BASE + 8'h0b, 16'h7077);
      wr(FLAG_BASE + 8'h02, 16'hffff);
      rd_chk(FLAG_BASE + 8'h02, 16'hbfff);
      wr(FLAG_BASE + 8'h02, 16'h0000);
      boot_segment_in <= 1'b1;
      alt_table_fuse_in <= 1'b1;
      wr(CTRL_ADDR, 16'h8100);
      arm(0, 7);
      pulse(NUM_REQ'(1'b1));
      serve(8, 7, 1'b1);
      alt_table_fuse_in <= 1'b0;
      pulse(NUM_REQ'(1'b1));
      serve(8, 7, 1'b0);
      final_report;
   end
endmodule

//--- tb/vic_monitor.sv
// checker of the controller's grant, fetch, return and register answers
// assumes the controller top's ports; attached by the bind at the foot
module vic_monitor (
   input wire logic                       mclk_in,
   input wire logic                       rst_in,
   input wire vic_pkg::reg_req_t          reg_in,
   input wire logic [vic_pkg::DATA_W-1:0] rdata_out,
   input wire logic                       core_ack_in,
   input wire logic                       core_ret_in,
   input wire vic_pkg::grant_t            grant_out,
   input wire vic_pkg::handler_t          handler_out,
   input wire logic                       ret_done_out,
   input wire logic                       boot_segment_in,
   input wire logic                       alt_table_fuse_in,
   input wire logic [vic_pkg::PM_W-1:0]   pm_addr_out,
   input wire logic                       pm_rd_out,
   input wire logic [vic_pkg::PM_W-1:0]   pm_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import vic_pkg::*;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   property p_ack_drop;
      grant_out.req && core_ack_in |=> !grant_out.req;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("req after ack");

   property p_req_hold;
      grant_out.req && !core_ack_in |=> grant_out.req && $stable(grant_out);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("grant moved");

   property p_entry;
      grant_out.req && core_ack_in |-> ##2 pm_rd_out ##1 handler_out.valid;
   endproperty
   a_entry: assert property (p_entry) else $error("entry latency");

   property p_ret;
      core_ret_in |-> ##3 ret_done_out;
   endproperty
   a_ret: assert property (p_ret) else $error("return latency");

   property p_prim_addr;
      pm_rd_out && !(boot_segment_in && alt_table_fuse_in) |->
         pm_addr_out == PRIMARY_BASE + (PM_W'(grant_out.vector) << 1);
   endproperty
   a_prim_addr: assert property (p_prim_addr)
      else $error("vector addr");

   property p_handler;
      pm_rd_out |=> handler_out.valid && handler_out.addr == $past(pm_data_in);
   endproperty
   a_handler: assert property (p_handler)
      else $error("handler addr");

   property p_trap_level;
      $rose(grant_out.req) && grant_out.vector < 8'h07 |->
         grant_out.level == 4'hf - grant_out.vector[3:0];
   endproperty
   a_trap_level: assert property (p_trap_level)
      else $error("trap lvl");

   property p_reserved;
      reg_in.rd && (reg_in.addr == FLAG_BASE + 8'h02 ||
         reg_in.addr == EN_BASE + 8'h02) |=> rdata_out[14] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bit");
endmodule

bind vectored_interrupt_controller vic_monitor i_vic_monitor (
   .mclk_in, .rst_in, .reg_in, .rdata_out, .core_ack_in, .core_ret_in,
   .grant_out, .handler_out, .ret_done_out, .boot_segment_in,
   .alt_table_fuse_in, .pm_addr_out, .pm_rd_out, .pm_data_in);
